//--- rtl/smog_guard.sv
/*
  Secure mode supervisor, fault responder and protected OTP region guard.
  Assumes a classic Wishbone master, fuse words stable while loading,
  fault inputs synchronous to sys_clk_i and an outside reset generator
  acting on fault_rst_o.
*/
// Function
// - Every reset loads fuses, then enters boot mode or halt
// - Boot mode reachable only through reset
// - Boot leaves only to test or firmware
// - Firmware mode never switches to test
// - After delivery test mode, test ROM disabled
// - After delivery only firmware mode reachable
// - Region sits in top 768 NVM bytes
// - Region accesses checked against mode, mapping
// - Fuses integrity-checked when loaded at reset
// - 32-byte user area is read only
// - 16-byte area writable until software locks
// - 32-byte area bits set once, never cleared
// - Card disable byte stops start after reset
// - Erase byte destroys application flash, NVM
// - Faults force reset or raise exception
// - Fault reset restarts and records its cause
// - Fault exception vectors and records cause
// - ROM parity failure forces reset
// - NVM corrects one bit; worse resets
// - Background RAM parity scan mismatch resets
// - Optional RAM read parity check resets
`timescale 1ns/1ps
`default_nettype none
`include "smog_consts.svh"

module smog_guard #(
  parameter int          N_SENS     = 4,
  parameter int          ADDR_W     = 12,
  parameter int          NVM_BYTES  = 65536,
  parameter logic [31:0] EXC_VECTOR = 32'h0000_0010,
  parameter logic [255:0] RO_CONTENT = 256'h0
) (
  input  wire logic              sys_clk_i,
  input  wire logic              rst_i,
  // Wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // CPU context and fuses
  input  wire logic              cpu_sys_i,
  input  wire logic [15:0]       fuse_word_i,
  input  wire logic [15:0]       fuse_chk_i,
  // Fault sources
  input  wire logic [N_SENS-1:0] sens_alarm_i,
  input  wire logic              rom_par_err_i,
  input  wire logic              nvm_ecc_corr_i,
  input  wire logic              nvm_ecc_fail_i,
  input  wire logic              ram_one_scan_err_i,
  input  wire logic              ram_two_scan_err_i,
  input  wire logic              ram_one_rd_par_err_i,
  input  wire logic              ram_two_rd_par_err_i,
  // Outcomes
  output smog_pkg::smog_mode_t   mode_o,
  output logic                   test_rom_en_o,
  output logic                   fault_rst_o,
  output logic                   exc_o,
  output logic      [31:0]       exc_vec_o,
  output logic                   erase_all_o,
  output logic                   light_det_en_o,
  output logic                   prot_acc_o,
  output logic      [31:0]       prot_phys_addr_o
);
  import smog_pkg::*;

  // ----------------------------------------------------------------------
  // Persistent storage of the protected region
  // ----------------------------------------------------------------------
  localparam int WP_WORDS  = `SMOG_WP_BYTES / 4;
  localparam int OTP_WORDS = `SMOG_OTP_BYTES / 4;

  // Non-volatile cells: erased state at manufacture, never cleared by
  // rst_i, otherwise a reset would undo a lock or a one-time bit.
  logic [31:0] wp_mem  [WP_WORDS]  = '{default: 32'h0000_0000};
  logic [31:0] otp_mem [OTP_WORDS] = '{default: 32'h0000_0000};
  logic        wp_lock_q           = 1'b0;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Byte-lane merge honouring wb_sel_i
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction : lane_mask

  // True when addr lies in a window of given base and byte size
  function automatic logic in_win(input logic [ADDR_W-1:0] a,
                                  input logic [ADDR_W-1:0] base,
                                  input int                bytes);
    in_win = (a >= base) && (32'(a) < 32'(base) + 32'(bytes));
  endfunction : in_win

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  smog_mode_t  mode_q;
  logic        ack_q;
  logic [31:0] rdata_q;
  logic [15:0] fuse_q;
  logic        fuse_ok_q;
  logic [31:0] map_q;
  logic [31:0] pol_q;
  logic [31:0] rst_cause_q;
  logic [31:0] exc_cause_q;
  logic [15:0] ecc_cnt_q;
  logic        mode_ref_q;
  logic        fault_rst_q;
  logic        exc_q;
  logic        erase_q;
  logic        prot_acc_q;
  logic [31:0] phys_q;

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  logic              req;
  logic              wr;
  logic [ADDR_W-1:0] off;
  logic              hit_ro;
  logic              hit_wp;
  logic              hit_otp;
  logic              hit_prot;
  logic              prot_ok;
  logic [2:0]        ro_idx;
  logic [1:0]        wp_idx;
  logic [2:0]        otp_idx;
  logic [31:0]       msk;

  assign req      = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr       = req & wb_we_i;
  assign off      = wb_adr_i - `SMOG_RO_BASE;
  assign hit_ro   = in_win(wb_adr_i, `SMOG_RO_BASE, `SMOG_RO_BYTES);
  assign hit_wp   = in_win(wb_adr_i, `SMOG_WP_BASE, `SMOG_WP_BYTES);
  assign hit_otp  = in_win(wb_adr_i, `SMOG_OTP_BASE, `SMOG_OTP_BYTES);
  assign hit_prot = hit_ro | hit_wp | hit_otp;
  assign ro_idx   = wb_adr_i[4:2];
  assign wp_idx   = wb_adr_i[3:2];
  assign otp_idx  = wb_adr_i[4:2];
  assign msk      = lane_mask(wb_sel_i);

  // Supervisor modes reach the region once start-up finished; system/user code
  // only when the mapping bit also exposes it, and never in load or halt.
  assign prot_ok = (mode_q != SMOG_LOAD) && (mode_q != SMOG_HALT) &&
                   (~cpu_sys_i | map_q[`SMOG_MAP_SYS_BIT]);

  // ----------------------------------------------------------------------
  // Fault collection
  // ----------------------------------------------------------------------
  logic [N_SENS-1:0] sens_rst;
  logic [N_SENS-1:0] sens_exc;
  logic              mem_fault;
  logic              any_rst;
  logic              acc_viol;
  logic              card_dis;

  // Sensor policy bit 1 routes an alarm to an exception, 0 to a reset
  assign sens_rst = sens_alarm_i & ~pol_q[N_SENS-1:0];
  assign sens_exc = sens_alarm_i &  pol_q[N_SENS-1:0];

  // Memory integrity failures always reset; read checks gated by fuses
  assign mem_fault = rom_par_err_i
                   | nvm_ecc_fail_i
                   | ram_one_scan_err_i | ram_two_scan_err_i
                   | (ram_one_rd_par_err_i & fuse_q[`SMOG_FUSE_R1_CHK])
                   | (ram_two_rd_par_err_i & fuse_q[`SMOG_FUSE_R2_CHK]);

  // Faults are meaningful only once fuses are in; before that we reload
  assign any_rst  = (mode_q != SMOG_LOAD) && ((|sens_rst) | mem_fault);
  assign acc_viol = req & hit_prot & ~prot_ok;

  assign card_dis = fuse_q[`SMOG_FUSE_CARD_EN] &&
    (otp_mem[`SMOG_CARD_DIS_WORD][`SMOG_CARD_DIS_LANE*8 +: 8] != 8'h00);

  // ----------------------------------------------------------------------
  // Mode sequencer
  // ----------------------------------------------------------------------
  smog_req_t mreq;
  logic      mode_wr;
  logic      mode_bad;

  assign mreq    = smog_req_t'(wb_dat_i[1:0]);
  assign mode_wr = wr && (wb_adr_i == `SMOG_MODE_CTRL) && wb_sel_i[0];

  // Requests that the sequencer refuses; requests for boot never pass
  always_comb begin
    mode_bad = 1'b0;
    if (mode_wr) begin
      unique case (mreq)
        SMOG_REQ_BOOT: mode_bad = 1'b1;
        SMOG_REQ_TEST: mode_bad = (mode_q != SMOG_BOOT)
                                | fuse_q[`SMOG_FUSE_DELIV];
        SMOG_REQ_FW:   mode_bad = (mode_q != SMOG_BOOT)
                                & (mode_q != SMOG_FW);
        SMOG_REQ_NONE: mode_bad = 1'b0;
      endcase
    end
  end

  // Reset and fault reset both restart through the fuse load, which is
  // the only door into boot mode.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      mode_q <= SMOG_LOAD;
    end else if (any_rst) begin
      mode_q <= SMOG_LOAD;
    end else begin
      unique case (mode_q)
        SMOG_LOAD: begin
          if (fuse_chk_i != ~fuse_word_i) begin
            mode_q <= SMOG_HALT;
          end else if (fuse_word_i[`SMOG_FUSE_CARD_EN] &&
              otp_mem[`SMOG_CARD_DIS_WORD][`SMOG_CARD_DIS_LANE*8 +: 8]
              != 8'h00) begin
            mode_q <= SMOG_HALT;
          end else begin
            mode_q <= SMOG_BOOT;
          end
        end
        SMOG_BOOT: begin
          if (mode_wr && !mode_bad && mreq == SMOG_REQ_TEST) begin
            mode_q <= SMOG_TEST;
          end else if (mode_wr && !mode_bad && mreq == SMOG_REQ_FW) begin
            mode_q <= SMOG_FW;
          end
        end
        SMOG_TEST: begin
          if (fuse_q[`SMOG_FUSE_DELIV]) begin
            mode_q <= SMOG_HALT;
          end
        end
        SMOG_FW:   mode_q <= SMOG_FW;
        SMOG_HALT: mode_q <= SMOG_HALT;
      endcase
    end
  end

  // Fuses are caught on the load cycle, a clocked sample after release
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      fuse_q    <= 16'h0001;
      fuse_ok_q <= 1'b0;
    end else if (mode_q == SMOG_LOAD) begin
      fuse_q    <= fuse_word_i;
      fuse_ok_q <= (fuse_chk_i == ~fuse_word_i);
    end
  end

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      map_q <= `SMOG_MAP_RST;
      pol_q <= 32'h0000_0000;
    end else if (wr && !cpu_sys_i) begin
      if (wb_adr_i == `SMOG_MAP_CTRL) begin
        map_q <= (map_q & ~msk) | (wb_dat_i & msk);
      end
      if (wb_adr_i == `SMOG_FAULT_POL) begin
        pol_q <= (pol_q & ~msk) | (wb_dat_i & msk);
      end
    end
  end

  // Reset cause survives the fault restart it reports; set beats clear
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rst_cause_q <= 32'h0000_0001;
    end else begin
      logic [31:0] set;
      set = 32'h0000_0000;
      set[`SMOG_RC_SENS]    = (mode_q != SMOG_LOAD) & (|sens_rst);
      set[`SMOG_RC_ROM]     = (mode_q != SMOG_LOAD) & rom_par_err_i;
      set[`SMOG_RC_ECC]     = (mode_q != SMOG_LOAD) & nvm_ecc_fail_i;
      set[`SMOG_RC_R1_SCAN] = (mode_q != SMOG_LOAD) & ram_one_scan_err_i;
      set[`SMOG_RC_R2_SCAN] = (mode_q != SMOG_LOAD) & ram_two_scan_err_i;
      set[`SMOG_RC_R1_READ] = (mode_q != SMOG_LOAD) &
                              ram_one_rd_par_err_i & fuse_q[`SMOG_FUSE_R1_CHK];
      set[`SMOG_RC_R2_READ] = (mode_q != SMOG_LOAD) &
                              ram_two_rd_par_err_i & fuse_q[`SMOG_FUSE_R2_CHK];
      set[`SMOG_RC_FUSE]    = (mode_q == SMOG_LOAD) &
                              (fuse_chk_i != ~fuse_word_i);
      if (wr && wb_adr_i == `SMOG_RST_CAUSE) begin
        rst_cause_q <= (rst_cause_q & ~(wb_dat_i & msk)) | set;
      end else begin
        rst_cause_q <= rst_cause_q | set;
      end
    end
  end

  // Exception cause: sensors, refused region access, refused mode change
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      exc_cause_q <= 32'h0000_0000;
    end else begin
      logic [31:0] set;
      set = 32'h0000_0000;
      set[N_SENS-1:0]      = sens_exc;
      set[`SMOG_EC_ACCESS] = acc_viol;
      set[`SMOG_EC_MODE]   = mode_bad;
      if (wr && wb_adr_i == `SMOG_EXC_CAUSE) begin
        exc_cause_q <= (exc_cause_q & ~(wb_dat_i & msk)) | set;
      end else begin
        exc_cause_q <= exc_cause_q | set;
      end
    end
  end

  // Corrected single-bit events, saturating, for software health checks
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ecc_cnt_q <= 16'h0000;
    end else if (nvm_ecc_corr_i && ecc_cnt_q != 16'hFFFF) begin
      ecc_cnt_q <= ecc_cnt_q + 16'h0001;
    end
  end

  // ----------------------------------------------------------------------
  // Protected region writes
  // ----------------------------------------------------------------------
  // The read-only area has no write port at all, so it cannot change.
  always_ff @(posedge sys_clk_i) begin
    if (wr && prot_ok && hit_wp && !wp_lock_q) begin
      wp_mem[wp_idx] <= (wp_mem[wp_idx] & ~msk) | (wb_dat_i & msk);
    end
    if (wr && prot_ok && hit_otp) begin
      otp_mem[otp_idx] <= otp_mem[otp_idx] | (wb_dat_i & msk);
    end
    if (wr && !cpu_sys_i && wb_adr_i == `SMOG_WP_LOCK && wb_dat_i[0]) begin
      wp_lock_q <= 1'b1;
    end
  end

  // Erase fires once when software sets the erase byte, if allowed
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      erase_q <= 1'b0;
    end else begin
      erase_q <= wr && prot_ok && hit_otp && fuse_q[`SMOG_FUSE_ERASE_EN] &&
                 otp_idx == 3'(`SMOG_ERASE_WORD) &&
                 wb_sel_i[`SMOG_ERASE_LANE] &&
                 wb_dat_i[`SMOG_ERASE_LANE*8 +: 8] != 8'h00 &&
                 otp_mem[`SMOG_ERASE_WORD][`SMOG_ERASE_LANE*8 +: 8]
                   == 8'h00;
    end
  end

  // Physical NVM address of each granted region access
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      prot_acc_q <= 1'b0;
      phys_q     <= 32'h0000_0000;
    end else begin
      prot_acc_q <= req & hit_prot & prot_ok;
      if (req && hit_prot && prot_ok) begin
        phys_q <= 32'(NVM_BYTES - `SMOG_PROT_BYTES) + 32'(off);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Fault outcomes
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      fault_rst_q <= 1'b0;
      exc_q       <= 1'b0;
      mode_ref_q  <= 1'b0;
    end else begin
      fault_rst_q <= any_rst;
      exc_q       <= (|sens_exc) | acc_viol | mode_bad;
      if (mode_bad) begin
        mode_ref_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read path and acknowledge
  // ----------------------------------------------------------------------
  // One wait state: ack follows the request edge; unmapped reads zero.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q   <= req;
      rdata_q <= 32'h0000_0000;
      if (req && !wb_we_i) begin
        if (hit_ro && prot_ok) begin
          rdata_q <= RO_CONTENT[ro_idx*32 +: 32];
        end else if (hit_wp && prot_ok) begin
          rdata_q <= wp_mem[wp_idx];
        end else if (hit_otp && prot_ok) begin
          rdata_q <= otp_mem[otp_idx];
        end else begin
          unique case (wb_adr_i)
            `SMOG_MODE_CTRL: rdata_q <= {29'h0, mode_q};
            `SMOG_MAP_CTRL:  rdata_q <= map_q;
            `SMOG_FAULT_POL: rdata_q <= pol_q;
            `SMOG_RST_CAUSE: rdata_q <= rst_cause_q;
            `SMOG_EXC_CAUSE: rdata_q <= exc_cause_q;
            `SMOG_STATUS:    rdata_q <= {8'h0, fuse_q, 3'h0, card_dis,
                                         mode_ref_q, wp_lock_q,
                                         fuse_ok_q, 1'b0};
            `SMOG_WP_LOCK:   rdata_q <= {31'h0, wp_lock_q};
            `SMOG_ECC_COUNT: rdata_q <= {16'h0, ecc_cnt_q};
            default:         rdata_q <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign wb_ack_o         = ack_q;
  assign wb_dat_o         = rdata_q;
  assign mode_o           = mode_q;
  assign test_rom_en_o    = (mode_q == SMOG_TEST)
                          & ~fuse_q[`SMOG_FUSE_DELIV];
  assign fault_rst_o      = fault_rst_q;
  assign exc_o            = exc_q;
  assign exc_vec_o        = EXC_VECTOR;
  assign erase_all_o      = erase_q;
  assign light_det_en_o   = map_q[`SMOG_MAP_LIGHT_BIT];
  assign prot_acc_o       = prot_acc_q;
  assign prot_phys_addr_o = phys_q;

endmodule : smog_guard
`default_nettype wire

//--- rtl/smog_consts.svh
/*
  Offsets, field positions, reset values and designated bytes of the
  secure mode and OTP guard.
  Assumes byte addressing on a 32-bit classic Wishbone bus.
*/
`ifndef SMOG_CONSTS_SVH
`define SMOG_CONSTS_SVH

// ----------------------------------------------------------------------
// Control registers (byte addresses)
// ----------------------------------------------------------------------
`define SMOG_MODE_CTRL   12'h000
`define SMOG_MAP_CTRL    12'h004
`define SMOG_FAULT_POL   12'h008
`define SMOG_RST_CAUSE   12'h00C
`define SMOG_EXC_CAUSE   12'h010
`define SMOG_STATUS      12'h014
`define SMOG_WP_LOCK     12'h018
`define SMOG_ECC_COUNT   12'h01C

// ----------------------------------------------------------------------
// Protected region windows (byte addresses)
// ----------------------------------------------------------------------
`define SMOG_RO_BASE     12'h100
`define SMOG_WP_BASE     12'h120
`define SMOG_OTP_BASE    12'h140
`define SMOG_RO_BYTES    32
`define SMOG_WP_BYTES    16
`define SMOG_OTP_BYTES   32
`define SMOG_PROT_BYTES  768

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define SMOG_MAP_SYS_BIT     0
`define SMOG_MAP_LIGHT_BIT   1
`define SMOG_MAP_RST         32'h0000_0002
`define SMOG_FUSE_DELIV      0
`define SMOG_FUSE_CARD_EN    1
`define SMOG_FUSE_ERASE_EN   2
`define SMOG_FUSE_R1_CHK     3
`define SMOG_FUSE_R2_CHK     4
`define SMOG_RC_EXT          0
`define SMOG_RC_SENS         1
`define SMOG_RC_ROM          2
`define SMOG_RC_ECC          3
`define SMOG_RC_R1_SCAN      4
`define SMOG_RC_R2_SCAN      5
`define SMOG_RC_R1_READ      6
`define SMOG_RC_R2_READ      7
`define SMOG_RC_FUSE         8
`define SMOG_EC_ACCESS       8
`define SMOG_EC_MODE         9
`define SMOG_CARD_DIS_WORD   7
`define SMOG_CARD_DIS_LANE   3
`define SMOG_ERASE_WORD      7
`define SMOG_ERASE_LANE      2

`endif

//--- rtl/smog_pkg.sv
/*
  Types of the secure mode and OTP guard.
  Assumes the constants header is included by the design file.
*/
package smog_pkg;

  // Supervisor state: load runs fuses, halt means start-up refused
  typedef enum logic [2:0] {
    SMOG_LOAD,
    SMOG_BOOT,
    SMOG_TEST,
    SMOG_FW,
    SMOG_HALT
  } smog_mode_t;

  // Codes software writes to request a mode
  typedef enum logic [1:0] {
    SMOG_REQ_BOOT = 2'h0,
    SMOG_REQ_TEST = 2'h1,
    SMOG_REQ_FW   = 2'h2,
    SMOG_REQ_NONE = 2'h3
  } smog_req_t;

endpackage : smog_pkg

//--- tb/smog_guard_properties.sv
/*
  Port checker of the secure mode and OTP guard.
  Assumes it is bound onto every smog_guard instance.
*/
`timescale 1ns/1ps
`default_nettype none
module smog_guard_properties #(
  parameter int ADDR_W    = 12,
  parameter int NVM_BYTES = 65536
) (
  input wire logic                 sys_clk_i,
  input wire logic                 rst_i,
  input wire logic                 wb_cyc_i,
  input wire logic                 wb_stb_i,
  input wire logic                 wb_ack_o,
  input wire logic [ADDR_W-1:0]    wb_adr_i,
  input wire smog_pkg::smog_mode_t mode_o,
  input wire logic                 test_rom_en_o,
  input wire logic                 fault_rst_o,
  input wire logic                 rom_par_err_i,
  input wire logic                 nvm_ecc_fail_i,
  input wire logic                 ram_one_scan_err_i,
  input wire logic                 ram_two_scan_err_i,
  input wire logic                 prot_acc_o,
  input wire logic [31:0]          prot_phys_addr_o
);
  import smog_pkg::*;
  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus answer late");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus answer held");
  a_load_exit: assert property (mode_o == SMOG_LOAD |-> ##[1:2]
    mode_o inside {SMOG_BOOT, SMOG_HALT}) else $error("load stuck");
  a_no_boot_back: assert property (mode_o inside {SMOG_TEST, SMOG_FW,
    SMOG_HALT} |=> mode_o != SMOG_BOOT) else $error("boot re-entered");
  a_fw_no_test: assert property (mode_o == SMOG_FW |=>
    mode_o != SMOG_TEST) else $error("firmware went to test");
  a_test_rom: assert property (test_rom_en_o |-> mode_o == SMOG_TEST)
    else $error("test rom enabled outside test");
  a_rom_reset: assert property (rom_par_err_i && mode_o != SMOG_LOAD |=>
    fault_rst_o && mode_o == SMOG_LOAD) else $error("rom fault missed");
  a_ecc_reset: assert property (nvm_ecc_fail_i && mode_o != SMOG_LOAD
    |=> fault_rst_o) else $error("ecc fault missed");
  a_scan_reset: assert property ((ram_one_scan_err_i || ram_two_scan_err_i)
    && mode_o != SMOG_LOAD |=> fault_rst_o) else $error("scan fault missed");
  a_phys_addr: assert property (prot_acc_o |-> prot_phys_addr_o ==
    32'(NVM_BYTES - 768) + 32'($past(wb_adr_i)) - 32'h100)
    else $error("region address wrong");
endmodule : smog_guard_properties
bind smog_guard smog_guard_properties #(.ADDR_W(ADDR_W),
  .NVM_BYTES(NVM_BYTES)) u_chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .wb_adr_i(wb_adr_i), .mode_o(mode_o), .test_rom_en_o(test_rom_en_o),
  .fault_rst_o(fault_rst_o), .rom_par_err_i(rom_par_err_i),
  .nvm_ecc_fail_i(nvm_ecc_fail_i), .ram_one_scan_err_i(ram_one_scan_err_i),
  .ram_two_scan_err_i(ram_two_scan_err_i), .prot_acc_o(prot_acc_o),
  .prot_phys_addr_o(prot_phys_addr_o));
`default_nettype wire

//--- tb/smog_guard_tb.sv
/*
  Self-checking bench of the secure mode and OTP guard.
  Assumes the constants header and package are compiled beside it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "smog_consts.svh"
module smog_guard_tb;
  import smog_pkg::*;
  logic        sys_clk_i, rst_i, cyc, we, cpu_sys, rom_e, ecc_e, scan_e, ack;
  logic [11:0] adr;
  logic [3:0]  sel, sens;
  logic [15:0] fuse, fchk;
  logic [31:0] wdat, rdat, q, vec;
  smog_mode_t  mode;
  logic        trom, exc, erase, lde;
  int          n_errors, tests_run, n_exc, n_erase;
  smog_guard uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .cpu_sys_i(cpu_sys),
    .fuse_word_i(fuse), .fuse_chk_i(fchk), .sens_alarm_i(sens),
    .rom_par_err_i(rom_e), .nvm_ecc_corr_i(1'b0), .nvm_ecc_fail_i(ecc_e),
    .ram_one_scan_err_i(scan_e), .ram_two_scan_err_i(1'b0),
    .ram_one_rd_par_err_i(scan_e), .ram_two_rd_par_err_i(1'b0),
    .mode_o(mode), .test_rom_en_o(trom), .fault_rst_o(), .exc_o(exc),
    .exc_vec_o(vec), .erase_all_o(erase), .light_det_en_o(lde), .prot_acc_o(),
    .prot_phys_addr_o());
  // ------------------------------------------------------------------
  // Clock, pulse counters, watchdog
  // ------------------------------------------------------------------
  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  // Pulses counted mid-cycle, where they are settled
  always @(negedge sys_clk_i) begin
    if (exc === 1'b1) n_exc++;
    if (erase === 1'b1) n_erase++;
  end
  // Whole run needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    n_errors++;
    complete_run();
  end
  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task complete_run;
    $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One classic cycle; ack and read data taken at the same rising edge
  task wb(input logic w, input logic [11:0] a, input logic [3:0] s,
          input logic [31:0] d);
    cyc <= 1'b1; we <= w; adr <= a; sel <= s; wdat <= d;
    do @(posedge sys_clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0; we <= 1'b0;
    @(posedge sys_clk_i);
  endtask : wb
  task ckmode(input smog_mode_t m);
    @(negedge sys_clk_i);
    chk({29'h0, mode}, {29'h0, m});
    @(posedge sys_clk_i);
  endtask : ckmode
  task boot(input logic [15:0] f, input logic [15:0] c);
    fuse <= f; fchk <= c; rst_i <= 1'b1;
    repeat (20) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
  endtask : boot
  // ------------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------------
  initial begin
    rst_i = 1'b1; cyc = 1'b0; we = 1'b0; adr = 12'h0; sel = 4'hF;
    wdat = 32'h0; cpu_sys = 1'b0; sens = 4'h0; rom_e = 1'b0;
    ecc_e = 1'b0; scan_e = 1'b0; fuse = 16'h0; fchk = 16'hFFFF;
    n_errors = 0; tests_run = 0; n_exc = 0; n_erase = 0;
    boot(16'h0006, 16'hFFF9);
    ckmode(SMOG_BOOT);
    wb(1'b1, `SMOG_MODE_CTRL, 4'hF, 32'h1);
    ckmode(SMOG_TEST);
    chk({31'h0, trom}, 32'h1);
    wb(1'b1, `SMOG_MODE_CTRL, 4'hF, 32'h0);
    ckmode(SMOG_TEST);
    boot(16'h0006, 16'hFFF9);
    wb(1'b1, `SMOG_MODE_CTRL, 4'hF, 32'h2);
    ckmode(SMOG_FW);
    wb(1'b1, `SMOG_MODE_CTRL, 4'hF, 32'h1);
    ckmode(SMOG_FW);
    wb(1'b1, `SMOG_MODE_CTRL, 4'hF, 32'h0);
    ckmode(SMOG_FW);
    chk(32'(n_exc), 32'h3);
    $display("Mode sequencing test done");
    wb(1'b1, `SMOG_RO_BASE, 4'hF, 32'hFFFF_FFFF);
    wb(1'b0, `SMOG_RO_BASE, 4'hF, 32'h0);
    chk(q, 32'h0);
    wb(1'b1, `SMOG_WP_BASE, 4'hF, 32'h1234_5678);
    wb(1'b1, `SMOG_WP_LOCK, 4'hF, 32'h1);
    wb(1'b1, `SMOG_WP_BASE, 4'hF, 32'hFFFF_FFFF);
    wb(1'b0, `SMOG_WP_BASE, 4'hF, 32'h0);
    chk(q, 32'h1234_5678);
    wb(1'b1, `SMOG_OTP_BASE, 4'hF, 32'h0F);
    wb(1'b1, `SMOG_OTP_BASE, 4'hF, 32'hF0);
    wb(1'b1, `SMOG_OTP_BASE, 4'hF, 32'h0);
    wb(1'b0, `SMOG_OTP_BASE, 4'hF, 32'h0);
    chk(q, 32'hFF);
    cpu_sys <= 1'b1;
    wb(1'b0, `SMOG_WP_BASE, 4'hF, 32'h0);
    chk(q, 32'h0);
    chk(32'(n_exc), 32'h4);
    cpu_sys <= 1'b0;
    $display("Protected region test done");
    for (int k = 0; k < 3; k++) begin
      wb(1'b1, `SMOG_RST_CAUSE, 4'hF, 32'h1FF);
      {scan_e, ecc_e, rom_e} <= 3'(1 << k);
      @(posedge sys_clk_i);
      {scan_e, ecc_e, rom_e} <= 3'h0;
      repeat (4) @(posedge sys_clk_i);
      ckmode(SMOG_BOOT);
      wb(1'b0, `SMOG_RST_CAUSE, 4'hF, 32'h0);
      chk(q, 32'h4 << k);
    end
    // Sensor zero set to trap instead of restarting
    wb(1'b1, `SMOG_FAULT_POL, 4'hF, 32'h1);
    wb(1'b1, `SMOG_EXC_CAUSE, 4'hF, 32'h3FF);
    sens <= 4'h1;
    @(posedge sys_clk_i);
    sens <= 4'h0;
    repeat (2) @(posedge sys_clk_i);
    ckmode(SMOG_BOOT);
    wb(1'b0, `SMOG_EXC_CAUSE, 4'hF, 32'h0);
    chk(q, 32'h1);
    chk(vec, 32'h10);
    chk({31'h0, lde}, 32'h1);
    wb(1'b1, `SMOG_MAP_CTRL, 4'hF, 32'h0);
    chk({31'h0, lde}, 32'h0);
    wb(1'b1, 12'(`SMOG_OTP_BASE + 4 * `SMOG_ERASE_WORD), 4'h4, 32'h1_0000);
    repeat (2) @(posedge sys_clk_i);
    chk(32'(n_erase), 32'h1);
    $display("Fault response test done");
    boot(16'h0001, 16'hFFFE);
    wb(1'b1, `SMOG_MODE_CTRL, 4'hF, 32'h1);
    repeat (2) @(posedge sys_clk_i);
    chk({31'h0, mode == SMOG_TEST}, 32'h0);
    chk({31'h0, trom}, 32'h0);
    boot(16'h0006, 16'h0006);
    ckmode(SMOG_HALT);
    boot(16'h0006, 16'hFFF9);
    wb(1'b1, 12'(`SMOG_OTP_BASE + 4 * `SMOG_CARD_DIS_WORD), 4'h8,
       32'h0100_0000);
    boot(16'h0006, 16'hFFF9);
    ckmode(SMOG_HALT);
    $display("Delivery and disable test done");
    complete_run();
  end
endmodule : smog_guard_tb
`default_nettype wire
